// *** logic/mcc_ctrl.v ***
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "mcc_consts.vh"

// Overview of operation
// - Position mode: bit7 set on timer overflow
// - Overflow flag raises no interrupt
// - Speed mode: bit7 mirrors speed error pending
// - Position mode: bit6 is hardware zero-cross select
// - Speed mode: bit6 read-only encoder phase
// - Direction 1 when A leads B
// - Bit5 selects simulated zero-crossing event
// - Bit4 selects simulated commutation in auto-switch
// - Fast off: sample once at off end
// - Fast on: sample at fast clock enable while rate select clear, gated by pwm_on if demag field nonzero
// - Fast sampling forces minimum off time zero
// - Threshold 111 external, others internal levels
// - Reset clears whole control register
module mcc_ctrl (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // Avalon-MM slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Motor events
  input  wire        motor_timer_overflow,
  input  wire        speed_error_pending,
  input  wire        hw_zero_cross_event,
  input  wire        pwm_off_end,
  input  wire        pwm_on,
  input  wire        fast_sample_clock,
  input  wire        encoder_input_a,
  input  wire        encoder_input_b,
  // Derived controls
  output reg         zero_cross_sample,
  output reg         zero_cross_detected,
  output reg         hardware_zero_cross_select,
  output reg         simulated_zero_cross_select,
  output reg         use_simulated_commutation,
  output reg         use_external_reference,
  output reg  [2:0]  internal_threshold_code,
  output reg  [3:0]  effective_min_off_time
);
  // ****************************************
  // Registers
  // ****************************************
  reg  [7:0]  ctrl_c_reg;
  reg  [7:0]  ctrl_c_next;
  reg  [11:0] mode_reg;
  reg  [11:0] mode_next;
  reg         ack_reg;
  reg         ack_next;
  reg         enc_a_prev_reg;
  reg         dir_reg;
  reg         dir_next;
  reg         sample_next;
  reg  [31:0] read_next;
  wire [1:0]  enc_raw;
  wire [1:0]  enc_sync;
  wire        enc_a;
  wire        enc_b;
  wire [1:0]  sensor_mode_select;
  wire        position_mode;
  wire        fast_zero_cross_sampling;
  wire [3:0]  demag_sampling_field;
  wire [3:0]  min_off_time_field;
  wire        sampling_rate_select;
  wire        auto_switched_mode;
  wire [2:0]  reference_threshold_select;
  wire        req;
  wire        wr_ctrl_c;
  wire        wr_mode;
  wire        a_rise;
  wire [7:0]  ctrl_c_view;
  genvar      gi;

  // Bus handshake states
  localparam BUS_IDLE = 1'b0;
  localparam BUS_ACK  = 1'b1;

  function hit;
    input [3:0] a;
    input [3:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // ****************************************
  // Encoder pin synchronisers
  // ****************************************
  assign enc_raw = {encoder_input_b, encoder_input_a};

  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      mcc_sync i_mcc_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .din      (enc_raw[gi]),
        .dout     (enc_sync[gi])
      );
    end
  endgenerate

  assign enc_a = enc_sync[0];
  assign enc_b = enc_sync[1];

  // ****************************************
  // Mode register fields
  // ****************************************
  assign sensor_mode_select =
    mode_reg[`MCC_MODE_SENSOR_HI:`MCC_MODE_SENSOR_LO];
  assign auto_switched_mode   = mode_reg[`MCC_MODE_AUTOSW];
  assign sampling_rate_select = mode_reg[`MCC_MODE_RATE];
  assign demag_sampling_field =
    mode_reg[`MCC_MODE_DEMAG_HI:`MCC_MODE_DEMAG_LO];
  assign min_off_time_field =
    mode_reg[`MCC_MODE_OFFT_HI:`MCC_MODE_OFFT_LO];
  assign position_mode = (sensor_mode_select == `MCC_SENSOR_POSITION);
  assign fast_zero_cross_sampling = ctrl_c_reg[`MCC_BIT_FAST];
  assign reference_threshold_select =
    ctrl_c_reg[`MCC_VREF_HI:`MCC_VREF_LO];

  // ****************************************
  // Bus handshake: one wait cycle per access
  // ****************************************
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  assign wr_ctrl_c = avs_write & ack_reg & hit(avs_address,
                                               `MCC_ADDR_CTRL_C);
  assign wr_mode   = avs_write & ack_reg & hit(avs_address,
                                               `MCC_ADDR_MODE);

  // The state bit doubles as the acknowledge
  always @* begin
    ack_next = ack_reg;
    case (ack_reg)
      BUS_IDLE: begin
        if (req) begin
          ack_next = BUS_ACK;
        end
      end
      BUS_ACK: begin
        ack_next = BUS_IDLE;
      end
      default: begin
        ack_next = BUS_IDLE;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      ack_reg <= BUS_IDLE;
    end else begin
      ack_reg <= ack_next;
    end
  end

  // ****************************************
  // Encoder phase: sample B on A rising edge
  // ****************************************
  assign a_rise = enc_a & ~enc_a_prev_reg;

  always @* begin
    dir_next = dir_reg;
    if (a_rise) begin
      dir_next = ~enc_b;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      enc_a_prev_reg <= 1'b0;
      dir_reg        <= 1'b0;
    end else begin
      enc_a_prev_reg <= enc_a;
      dir_reg        <= dir_next;
    end
  end

  // ****************************************
  // Control register C and mode register
  // ****************************************
  always @* begin
    mode_next   = mode_reg;
    ctrl_c_next = ctrl_c_reg;
    if (wr_mode) begin
      mode_next = avs_writedata[11:0];
    end
    if (wr_ctrl_c) begin
      ctrl_c_next[6:0] = avs_writedata[6:0];
    end
    // Set wins over a clearing write in the same cycle
    if (position_mode & motor_timer_overflow) begin
      ctrl_c_next[`MCC_BIT_FLAG] = 1'b1;
    end else if (wr_ctrl_c & ~avs_writedata[`MCC_BIT_FLAG]) begin
      ctrl_c_next[`MCC_BIT_FLAG] = 1'b0;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      ctrl_c_reg <= `MCC_RESET_CTRL_C;
      mode_reg   <= `MCC_RESET_MODE;
    end else begin
      ctrl_c_reg <= ctrl_c_next;
      mode_reg   <= mode_next;
    end
  end

  // Bit 7 and bit 6 change meaning with the sensor mode
  assign ctrl_c_view = position_mode ? ctrl_c_reg :
    {speed_error_pending, dir_reg, ctrl_c_reg[5:0]};

  // ****************************************
  // Read data
  // ****************************************
  // Captured in the wait cycle, held until the next read
  always @* begin
    read_next = 32'h0000_0000;
    case (avs_address)
      `MCC_ADDR_CTRL_C: begin
        read_next = {24'h00_0000, ctrl_c_view};
      end
      `MCC_ADDR_MODE: begin
        read_next = {20'h0_0000, mode_reg};
      end
      `MCC_ADDR_STATUS: begin
        read_next = {29'h0000_0000, dir_reg, enc_b, enc_a};
      end
      default: begin
        read_next = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack_reg) begin
      avs_readdata <= read_next;
    end
  end

  // ****************************************
  // Zero-crossing sampling
  // ****************************************
  always @* begin
    if (fast_zero_cross_sampling & ~sampling_rate_select) begin
      if (demag_sampling_field != 4'h0) begin
        sample_next = fast_sample_clock & pwm_on;
      end else begin
        sample_next = fast_sample_clock;
      end
    end else begin
      sample_next = pwm_off_end;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      zero_cross_sample   <= 1'b0;
      zero_cross_detected <= 1'b0;
    end else begin
      zero_cross_sample   <= sample_next;
      zero_cross_detected <= zero_cross_sample & hw_zero_cross_event &
                             hardware_zero_cross_select;
    end
  end

  // ****************************************
  // Derived event and reference controls
  // ****************************************
  always @(posedge core_clk) begin
    if (rst) begin
      hardware_zero_cross_select  <= 1'b0;
      simulated_zero_cross_select <= 1'b0;
      use_simulated_commutation   <= 1'b0;
      use_external_reference      <= 1'b0;
      internal_threshold_code     <= 3'h0;
    end else begin
      hardware_zero_cross_select  <= position_mode &
                                     ctrl_c_reg[`MCC_BIT_DIR_HWZC];
      simulated_zero_cross_select <= ctrl_c_reg[`MCC_BIT_SIMZC];
      use_simulated_commutation   <= auto_switched_mode &
                                     ctrl_c_reg[`MCC_BIT_SIMCOM];
      use_external_reference      <=
        (reference_threshold_select == `MCC_VREF_EXTERNAL);
      internal_threshold_code     <= reference_threshold_select;
    end
  end

  // ****************************************
  // Minimum off time
  // ****************************************
  // Fast sampling leaves no room for a programmed off time
  always @(posedge core_clk) begin
    if (rst) begin
      effective_min_off_time <= 4'h0;
    end else if (fast_zero_cross_sampling) begin
      effective_min_off_time <= 4'h0;
    end else begin
      effective_min_off_time <= min_off_time_field;
    end
  end
endmodule // mcc_ctrl

// *** logic/mcc_consts.vh ***
`ifndef MCC_CONSTS_VH
`define MCC_CONSTS_VH
// ****************************************
// Register map (byte addresses)
// ****************************************
`define MCC_ADDR_CTRL_C      4'h0
`define MCC_ADDR_MODE        4'h4
`define MCC_ADDR_STATUS      4'h8
// ****************************************
// Control register C fields
// ****************************************
`define MCC_BIT_FLAG         7
`define MCC_BIT_DIR_HWZC     6
`define MCC_BIT_SIMZC        5
`define MCC_BIT_SIMCOM       4
`define MCC_BIT_FAST         3
`define MCC_VREF_HI          2
`define MCC_VREF_LO          0
`define MCC_RESET_CTRL_C     8'h00
`define MCC_VREF_EXTERNAL    3'h7
// ****************************************
// Mode register fields
// ****************************************
`define MCC_MODE_SENSOR_HI   1
`define MCC_MODE_SENSOR_LO   0
`define MCC_MODE_AUTOSW      2
`define MCC_MODE_RATE        3
`define MCC_MODE_DEMAG_HI    7
`define MCC_MODE_DEMAG_LO    4
`define MCC_MODE_OFFT_HI     11
`define MCC_MODE_OFFT_LO     8
`define MCC_RESET_MODE       12'h000
`define MCC_SENSOR_POSITION  2'h0
`endif

// *** logic/mcc_sync.v ***
`timescale 1ns/1ns
// ****************************************
// Three-stage synchroniser; change taken when stages 2 and 3 agree
// ****************************************
module mcc_sync (
  // Clock and reset
  input  wire core_clk,
  input  wire rst,
  // Data
  input  wire din,
  output reg  dout
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge core_clk) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout   <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end
endmodule // mcc_sync

// *** verif/mcc_ctrl_assertions.sv ***
`timescale 1ns/1ns
// ********
// Port checks of the control block
// ********
module mcc_ctrl_checker (
  // Clock and reset
  input wire        core_clk,
  input wire        rst,
  // Bus
  input wire        avs_read,
  input wire        avs_write,
  input wire        avs_waitrequest,
  input wire [31:0] avs_readdata,
  // Motor side
  input wire        pwm_off_end,
  input wire        fast_sample_clock,
  input wire        hw_zero_cross_event,
  input wire        zero_cross_sample,
  input wire        zero_cross_detected,
  input wire        hardware_zero_cross_select,
  input wire        use_external_reference,
  input wire [2:0]  internal_threshold_code,
  input wire [3:0]  effective_min_off_time
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wait_first_a: assert property ($rose(avs_read | avs_write)
    |-> avs_waitrequest) else $error("no wait cycle");
  one_wait_a: assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");
  idle_ready_a: assert property (!(avs_read | avs_write)
    |-> !avs_waitrequest) else $error("wait while idle");
  upper_zero_a: assert property (avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  ext_ref_a: assert property (
    use_external_reference == (internal_threshold_code == 3'h7))
    else $error("reference source wrong");
  sample_src_a: assert property (zero_cross_sample
    |-> $past(pwm_off_end | fast_sample_clock)) else $error("stray sample");
  detect_src_a: assert property (zero_cross_detected |-> $past(
    zero_cross_sample & hw_zero_cross_event & hardware_zero_cross_select))
    else $error("stray detection");
  reset_clr_a: assert property ($fell(rst) |->
    !use_external_reference && internal_threshold_code == 3'h0 &&
    effective_min_off_time == 4'h0 && !hardware_zero_cross_select)
    else $error("outputs not cleared");
endmodule // mcc_ctrl_checker

bind mcc_ctrl mcc_ctrl_checker i_mcc_ctrl_checker (.core_clk, .rst,
  .avs_read, .avs_write, .avs_waitrequest, .avs_readdata, .pwm_off_end,
  .fast_sample_clock, .hw_zero_cross_event, .zero_cross_sample,
  .zero_cross_detected, .hardware_zero_cross_select,
  .use_external_reference, .internal_threshold_code,
  .effective_min_off_time);

// *** verif/mcc_motor_model.sv ***
`timescale 1ns/1ns
// ********
// Quadrature encoder on the rotor shaft
// ********
module mcc_motor_model (
  // Control
  input  wire run,
  input  wire a_leads,
  // Encoder pins
  output reg  encoder_input_a,
  output reg  encoder_input_b
);
  initial begin
    encoder_input_a = 1'b0;
    encoder_input_b = 1'b0;
  end
  // Quarter step every 100 ns while turning, still otherwise
  always #100 if (run) begin
    if (a_leads == (encoder_input_a == encoder_input_b))
      encoder_input_a <= ~encoder_input_a;
    else
      encoder_input_b <= ~encoder_input_b;
  end
endmodule // mcc_motor_model

// *** verif/mcc_ctrl_tb.sv ***
`timescale 1ns/1ns
// ********
// Self-checking bench
// ********
module mcc_ctrl_tb;
  logic        core_clk, rst, avs_read, avs_write, run, a_leads, pwm_on;
  logic        motor_timer_overflow, speed_error_pending;
  logic        hw_zero_cross_event, pwm_off_end, fast_sample_clock;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, encoder_input_a, encoder_input_b;
  wire         zero_cross_sample, zero_cross_detected;
  wire         hardware_zero_cross_select, simulated_zero_cross_select;
  wire         use_simulated_commutation, use_external_reference;
  wire  [2:0]  internal_threshold_code;
  wire  [3:0]  effective_min_off_time;
  int          num_errors, n_compared, cycles;
  mcc_ctrl i_mcc_ctrl (.core_clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .motor_timer_overflow, .speed_error_pending, .hw_zero_cross_event,
    .pwm_off_end, .pwm_on, .fast_sample_clock, .encoder_input_a,
    .encoder_input_b, .zero_cross_sample, .zero_cross_detected,
    .hardware_zero_cross_select, .simulated_zero_cross_select,
    .use_simulated_commutation, .use_external_reference,
    .internal_threshold_code, .effective_min_off_time);
  mcc_motor_model i_mcc_motor_model (.run, .a_leads, .encoder_input_a,
    .encoder_input_b);
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop;
    end
  end
  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask
  task automatic zc(input logic off_end, fast, on, exp, det);
    pwm_off_end <= off_end;
    fast_sample_clock <= fast;
    pwm_on <= on;
    @(posedge core_clk);
    pwm_off_end <= 1'b0;
    fast_sample_clock <= 1'b0;
    @(posedge core_clk);
    chk(32'(zero_cross_sample), 32'(exp));
    @(posedge core_clk);
    chk(32'(zero_cross_detected), 32'(det));
  endtask
  task automatic t_reset;
    rd_chk(4'h0, 32'h0000_0000);
    rd_chk(4'h4, 32'h0000_0000);
    rd_chk(4'hC, 32'h0000_0000);
  endtask
  task automatic t_fields;
    logic [31:0] e;
    wr(4'h4, 32'h0000_0504);
    for (int v = 0; v < 8; v++) begin
      e = {24'h00_0000, 4'h7, v[0], v[2:0]};
      wr(4'h0, e);
      rd_chk(4'h0, e);
      chk(32'(use_external_reference), 32'(v == 7));
      chk(32'(internal_threshold_code), 32'(v));
      chk(32'(effective_min_off_time), v[0] ? 0 : 5);
    end
    chk(32'(hardware_zero_cross_select), 1);
    chk(32'(simulated_zero_cross_select), 1);
    chk(32'(use_simulated_commutation), 1);
    wr(4'h0, 32'h0000_0060);
    chk(32'(use_simulated_commutation), 0);
    chk(32'(simulated_zero_cross_select), 1);
  endtask
  task automatic t_flag;
    wr(4'h0, 32'h0000_0000);
    motor_timer_overflow <= 1'b1;
    @(posedge core_clk);
    motor_timer_overflow <= 1'b0;
    rd_chk(4'h0, 32'h0000_0080);
    wr(4'h0, 32'h0000_0080);
    rd_chk(4'h0, 32'h0000_0080);
    wr(4'h0, 32'h0000_0000);
    rd_chk(4'h0, 32'h0000_0000);
  endtask
  task automatic t_speed;
    a_leads <= 1'b1;
    run <= 1'b1;
    repeat (50) @(posedge core_clk);
    run <= 1'b0;
    speed_error_pending <= 1'b1;
    for (int m = 1; m < 4; m++) begin
      wr(4'h4, 32'(m));
      rd_chk(4'h0, 32'h0000_00C0);
    end
    rd_chk(4'h8, 32'h0000_0007);
    speed_error_pending <= 1'b0;
    wr(4'h0, 32'h0000_0000);
    rd_chk(4'h0, 32'h0000_0040);
    a_leads <= 1'b0;
    run <= 1'b1;
    repeat (50) @(posedge core_clk);
    run <= 1'b0;
    rd_chk(4'h0, 32'h0000_0000);
    wr(4'h4, 32'h0000_0000);
  endtask
  task automatic t_sample;
    hw_zero_cross_event <= 1'b1;
    zc(1, 0, 0, 1, 0);
    wr(4'h0, 32'h0000_0040);
    zc(1, 0, 0, 1, 1);
    zc(0, 1, 0, 0, 0);
    wr(4'h0, 32'h0000_0048);
    zc(1, 0, 0, 0, 0);
    zc(0, 1, 0, 1, 1);
    wr(4'h4, 32'h0000_0010);
    zc(0, 1, 0, 0, 0);
    zc(0, 1, 1, 1, 1);
    wr(4'h4, 32'h0000_0008);
    zc(1, 0, 0, 1, 1);
    hw_zero_cross_event <= 1'b0;
    zc(1, 0, 0, 1, 0);
  endtask
  initial begin
    {core_clk, avs_read, avs_write, run, a_leads, pwm_on} = '0;
    {motor_timer_overflow, speed_error_pending, hw_zero_cross_event} = '0;
    {pwm_off_end, fast_sample_clock, avs_address, avs_writedata} = '0;
    rst = 1'b1;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_fields;
    t_flag;
    t_speed;
    t_sample;
    report_and_stop;
  end
endmodule // mcc_ctrl_tb
